/* inc/crs_regs.svh */
// crs_regs.svh: offsets, reset values, steps and field positions
// assumes an 8-bit apb byte address and 32-bit data words
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CRS_OFS_PC 8'h00
`define CRS_OFS_SP 8'h04
`define CRS_OFS_IX 8'h08
`define CRS_OFS_IY 8'h0c
`define CRS_OFS_IPAGE 8'h10
`define CRS_OFS_RFSH 8'h14
`define CRS_OFS_AF 8'h18
`define CRS_OFS_AF_ALT 8'h1c
`define CRS_OFS_PAIR1 8'h20
`define CRS_OFS_ALT_PAIR1 8'h2c
`define CRS_OFS_IR 8'h38
`define CRS_OFS_STAT 8'h3c
`define CRS_OFS_CTRL 8'h40
`define CRS_WORD_STEP 8'h04
// ----------------------------------------
// reset values and steps
// ----------------------------------------
`define CRS_RST_WORD 16'h0000
`define CRS_RST_BYTE 8'h00
`define CRS_RST_RFSH 7'h00
`define CRS_PC_STEP 16'h0001
`define CRS_SP_STEP 16'h0002
`define CRS_PTR_STEP 16'h0001
`define CRS_RFSH_STEP 7'h01
`define CRS_RFSH_PAD 9'h000
// ----------------------------------------
// field positions
// ----------------------------------------
`define CRS_FLG_S 7
`define CRS_FLG_Z 6
`define CRS_FLG_N 1
`define CRS_FLG_C 0
`define CRS_CTRL_VEC 0
`define CRS_STAT_AF 0
`define CRS_STAT_BANK 1
`define CRS_STAT_VEC 2
`endif

/* inc/crs_pkg.sv */
// crs_pkg: types shared by the register set and its bench
// assumes crs_regs.svh supplies all numeric constants
package crs_pkg;
    // ----------------------------------------
    // alu functions, all sixteen codes legal
    // ----------------------------------------
    typedef enum logic [3:0] {
        CRS_ADD, CRS_SUB, CRS_AND, CRS_OR, CRS_XOR, CRS_CMP,
        CRS_SLL, CRS_SRL, CRS_SRA, CRS_RL, CRS_RR,
        CRS_INC, CRS_DEC, CRS_BSET, CRS_BRES, CRS_BTST
    } crs_alu_op_t;
    // alu request from the decoder
    typedef struct packed {
        crs_alu_op_t op;
        logic [7:0] opnd;
        logic [2:0] bsel;
    } crs_alu_req_t;
    // opcode split into its three fields
    typedef struct packed {
        logic [1:0] grp;
        logic [2:0] dst;
        logic [2:0] src;
    } crs_dec_t;
    // address lines with their strobes
    typedef struct packed {
        logic [15:0] addr;
        logic fetch;
        logic rfsh;
    } crs_bus_t;
    // fetch sequencer states
    typedef enum logic [1:0] {
        CRS_ST_IDLE, CRS_ST_FETCH, CRS_ST_RFSH
    } crs_fetch_st_t;
endpackage

/* core/crs_core.sv */
// crs_core: programmer register set with fetch, stack, index and alu
// assumes a decoder on clk_sys driving one-cycle requests, apb master
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "crs_regs.svh"
module crs_core
    import crs_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // fetch and jump
    input wire logic fetch_req,
    input wire logic [7:0] fetch_data,
    input wire logic jump_req,
    input wire logic [15:0] jump_target,
    // stack, exchange, alu
    input wire logic push_req,
    input wire logic pop_req,
    input wire logic xchg_af,
    input wire logic xchg_bank,
    input wire logic alu_go,
    input wire crs_alu_req_t alu_req,
    // address generation
    input wire logic idx_req,
    input wire logic idx_sel,
    input wire logic [7:0] idx_disp,
    input wire logic ptr_req,
    input wire logic [1:0] ptr_sel,
    input wire logic ptr_hi,
    input wire logic int_ack,
    input wire logic [7:0] int_vec_lo,
    // results
    output crs_bus_t bus_out,
    output logic [7:0] ir_out,
    output crs_dec_t dec_out,
    output logic [7:0] flags_out,
    output logic [15:0] stk_addr,
    output logic [15:0] idx_addr,
    output logic [15:0] ptr_addr,
    output logic [15:0] int_addr,
    output logic int_addr_vld
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [15:0] pc_r; // fetch address
    logic [15:0] sp_r; // stack top
    logic [15:0] ix_r; // index base x
    logic [15:0] iy_r; // index base y
    logic [7:0] ipage_r; // interrupt page
    logic [6:0] rfsh_r; // refresh counter
    logic [7:0] acc_r [2];
    logic [7:0] flg_r [2]; // both flag bytes
    logic [15:0] gp_r [2][3]; // two banks, three pairs
    logic af_sel_r; // active accumulator pair
    logic bank_sel_r; // active general bank
    logic vec_mode_r; // vectored interrupt mode
    logic [7:0] ir_r; // instruction register
    crs_dec_t dec_r; // decoded fields
    crs_fetch_st_t st_r; // fetch sequencer
    crs_bus_t bus_r; // address lines
    logic [15:0] stk_addr_r;
    logic [15:0] idx_addr_r;
    logic [15:0] ptr_addr_r;
    logic [15:0] int_addr_r;
    logic int_vld_r;
    logic [31:0] prdata_r;
    logic slverr_r;
    // bus decode helpers
    logic apb_wr;
    logic [31:0] rd_mux;
    logic rd_err;
    logic [31:0] stat_w;
    // alu helpers
    logic [7:0] acc_a;
    logic [7:0] flg_a;
    logic [7:0] alu_res;
    logic [7:0] bmask;
    logic [8:0] sum9;
    logic alu_c;
    logic alu_z;
    logic alu_wr;
    logic [7:0] flg_nxt;

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    // no wait states; read data caught in the setup cycle
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = slverr_r;
    assign apb_wr = psel && penable && pwrite && !slverr_r;

    // status word built from live selects
    always_comb
    begin
        stat_w = 32'h0000_0000;
        stat_w[`CRS_STAT_AF] = af_sel_r;
        stat_w[`CRS_STAT_BANK] = bank_sel_r;
        stat_w[`CRS_STAT_VEC] = vec_mode_r;
    end

    // read mux, unmapped offsets answer with an error
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr)
            `CRS_OFS_PC: rd_mux = {16'h0000, pc_r};
            `CRS_OFS_SP: rd_mux = {16'h0000, sp_r};
            `CRS_OFS_IX: rd_mux = {16'h0000, ix_r};
            `CRS_OFS_IY: rd_mux = {16'h0000, iy_r};
            `CRS_OFS_IPAGE: rd_mux = {24'h00_0000, ipage_r};
            `CRS_OFS_RFSH: rd_mux = {25'h000_0000, rfsh_r};
            `CRS_OFS_AF: rd_mux = {16'h0000, acc_r[af_sel_r], flg_r[af_sel_r]};
            `CRS_OFS_AF_ALT: rd_mux = {16'h0000, acc_r[!af_sel_r], flg_r[!af_sel_r]};
            `CRS_OFS_PAIR1: rd_mux = {16'h0000, gp_r[bank_sel_r][0]};
            `CRS_OFS_PAIR1 + `CRS_WORD_STEP: rd_mux = {16'h0000, gp_r[bank_sel_r][1]};
            8'(`CRS_OFS_PAIR1 + 2 * `CRS_WORD_STEP): rd_mux = {16'h0000, gp_r[bank_sel_r][2]};
            `CRS_OFS_ALT_PAIR1: rd_mux = {16'h0000, gp_r[!bank_sel_r][0]};
            `CRS_OFS_ALT_PAIR1 + `CRS_WORD_STEP: rd_mux = {16'h0000, gp_r[!bank_sel_r][1]};
            8'(`CRS_OFS_ALT_PAIR1 + 2 * `CRS_WORD_STEP): rd_mux = {16'h0000, gp_r[!bank_sel_r][2]};
            `CRS_OFS_IR: rd_mux = {24'h00_0000, ir_r};
            `CRS_OFS_STAT: rd_mux = stat_w;
            `CRS_OFS_CTRL: rd_mux = {31'h0000_0000, vec_mode_r};
            default: rd_err = 1'b1; // unmapped
        endcase
    end

    // answer registered at setup, held through the access phase
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata_r <= 32'h0000_0000;
            slverr_r <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
            slverr_r <= rd_err;
        end
    end

    // ----------------------------------------
    // fetch sequencer and address lines
    // ----------------------------------------
    // a fetch request outside idle is dropped; decoder must wait
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= CRS_ST_IDLE;
        else
        begin
            unique case (st_r)
                CRS_ST_IDLE: if (fetch_req) st_r <= CRS_ST_FETCH;
                CRS_ST_FETCH: st_r <= CRS_ST_RFSH;
                CRS_ST_RFSH: st_r <= CRS_ST_IDLE;
            endcase
        end
    end

    // fetch address, then refresh address with its strobe
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            bus_r <= '0;
        else if (st_r == CRS_ST_IDLE && fetch_req)
            bus_r <= '{addr: pc_r, fetch: 1'b1, rfsh: 1'b0};
        else if (st_r == CRS_ST_FETCH)
            bus_r <= '{addr: {`CRS_RFSH_PAD, rfsh_r}, fetch: 1'b0, rfsh: 1'b1};
        else
            bus_r <= '{addr: bus_r.addr, fetch: 1'b0, rfsh: 1'b0};
    end

    // program counter: bus write, then jump, then increment
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            pc_r <= `CRS_RST_WORD;
        else if (apb_wr && paddr == `CRS_OFS_PC)
            pc_r <= pwdata[15:0];
        else if (jump_req)
            pc_r <= jump_target;
        else if (st_r == CRS_ST_IDLE && fetch_req)
            pc_r <= pc_r + `CRS_PC_STEP;
    end

    // refresh counter wraps in seven bits; a test write wins that cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rfsh_r <= `CRS_RST_RFSH;
        else if (apb_wr && paddr == `CRS_OFS_RFSH)
            rfsh_r <= pwdata[6:0];
        else if (st_r == CRS_ST_FETCH)
            rfsh_r <= rfsh_r + `CRS_RFSH_STEP;
    end

    // opcode latch and field split
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ir_r <= `CRS_RST_BYTE;
            dec_r <= '0;
        end
        else if (st_r == CRS_ST_FETCH)
        begin
            ir_r <= fetch_data;
            dec_r <= '{grp: fetch_data[7:6], dst: fetch_data[5:3], src: fetch_data[2:0]};
        end
    end

    // ----------------------------------------
    // stack, index, pointer, interrupt
    // ----------------------------------------
    // push predecrements, pop postincrements: last pushed is first popped
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            sp_r <= `CRS_RST_WORD;
        else if (apb_wr && paddr == `CRS_OFS_SP)
            sp_r <= pwdata[15:0];
        else if (push_req)
            sp_r <= sp_r - `CRS_SP_STEP;
        else if (pop_req)
            sp_r <= sp_r + `CRS_SP_STEP;
    end

    // stack word address handed to the memory bus
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            stk_addr_r <= `CRS_RST_WORD;
        else if (push_req)
            stk_addr_r <= sp_r - `CRS_SP_STEP;
        else if (pop_req)
            stk_addr_r <= sp_r;
    end

    // index bases and interrupt page are written by software only
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ix_r <= `CRS_RST_WORD;
            iy_r <= `CRS_RST_WORD;
            ipage_r <= `CRS_RST_BYTE;
            vec_mode_r <= 1'b0;
        end
        else if (apb_wr)
        begin
            if (paddr == `CRS_OFS_IX) ix_r <= pwdata[15:0];
            if (paddr == `CRS_OFS_IY) iy_r <= pwdata[15:0];
            if (paddr == `CRS_OFS_IPAGE) ipage_r <= pwdata[7:0];
            if (paddr == `CRS_OFS_CTRL) vec_mode_r <= pwdata[`CRS_CTRL_VEC];
        end
    end

    // indexed address, base left untouched
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            idx_addr_r <= `CRS_RST_WORD;
        else if (idx_req)
            idx_addr_r <= (idx_sel ? iy_r : ix_r) + {{8{idx_disp[7]}}, idx_disp};
    end

    // indirect word: low byte at pointer, high at pointer+1; sel 3 is sp
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            ptr_addr_r <= `CRS_RST_WORD;
        else if (ptr_req)
            ptr_addr_r <= ((ptr_sel == 2'b11) ? sp_r : gp_r[bank_sel_r][ptr_sel])
                + (ptr_hi ? `CRS_PTR_STEP : `CRS_RST_WORD);
    end

    // vectored call address, one-cycle valid; ignored outside that mode
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_addr_r <= `CRS_RST_WORD;
            int_vld_r <= 1'b0;
        end
        else
        begin
            int_vld_r <= int_ack && vec_mode_r;
            if (int_ack && vec_mode_r)
                int_addr_r <= {ipage_r, int_vec_lo};
        end
    end

    // exchanges flip a select, so the swap is atomic in one edge
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            af_sel_r <= 1'b0;
            bank_sel_r <= 1'b0;
        end
        else
        begin
            if (xchg_af) af_sel_r <= !af_sel_r;
            if (xchg_bank) bank_sel_r <= !bank_sel_r;
        end
    end

    // ----------------------------------------
    // alu on the active accumulator
    // ----------------------------------------
    assign acc_a = acc_r[af_sel_r];
    assign flg_a = flg_r[af_sel_r];
    assign bmask = 8'h01 << alu_req.bsel;

    // result, carry and write-back per function
    always_comb
    begin
        alu_res = acc_a;
        alu_c = flg_a[`CRS_FLG_C];
        alu_wr = 1'b1;
        sum9 = 9'h000;
        unique case (alu_req.op)
            CRS_ADD:
            begin
                sum9 = {1'b0, acc_a} + {1'b0, alu_req.opnd};
                {alu_c, alu_res} = sum9;
            end
            CRS_SUB, CRS_CMP:
            begin
                sum9 = {1'b0, acc_a} - {1'b0, alu_req.opnd};
                {alu_c, alu_res} = sum9;
                alu_wr = (alu_req.op == CRS_SUB); // compare keeps acc
            end
            CRS_AND: {alu_c, alu_res} = {1'b0, acc_a & alu_req.opnd};
            CRS_OR: {alu_c, alu_res} = {1'b0, acc_a | alu_req.opnd};
            CRS_XOR: {alu_c, alu_res} = {1'b0, acc_a ^ alu_req.opnd};
            CRS_SLL: {alu_c, alu_res} = {acc_a, 1'b0};
            CRS_SRL: {alu_res, alu_c} = {1'b0, acc_a};
            CRS_SRA: {alu_res, alu_c} = {acc_a[7], acc_a};
            CRS_RL: {alu_c, alu_res} = {acc_a[7], acc_a[6:0], acc_a[7]};
            CRS_RR: {alu_res, alu_c} = {acc_a[0], acc_a[7:1], acc_a[0]};
            CRS_INC: alu_res = acc_a + 8'h01;
            CRS_DEC: alu_res = acc_a - 8'h01;
            CRS_BSET: alu_res = acc_a | bmask;
            CRS_BRES: alu_res = acc_a & ~bmask;
            CRS_BTST: alu_wr = 1'b0;
        endcase
    end

    // flag byte: bit test reports the tested bit in zero
    always_comb
    begin
        alu_z = (alu_req.op == CRS_BTST) ? ((acc_a & bmask) == 8'h00)
            : (alu_res == 8'h00);
        flg_nxt = flg_a;
        flg_nxt[`CRS_FLG_S] = alu_res[7];
        flg_nxt[`CRS_FLG_Z] = alu_z;
        flg_nxt[`CRS_FLG_N] = (alu_req.op == CRS_SUB) || (alu_req.op == CRS_CMP)
            || (alu_req.op == CRS_DEC);
        flg_nxt[`CRS_FLG_C] = alu_c;
    end

    // ----------------------------------------
    // duplicated accumulator, flag and general banks
    // ----------------------------------------
    // software always sees the active entry at the plain offset
    generate
        for (genvar b = 0; b < 2; b++)
        begin : g_bank
            always_ff @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    acc_r[b] <= `CRS_RST_BYTE;
                    flg_r[b] <= `CRS_RST_BYTE;
                end
                else if (apb_wr && paddr == ((af_sel_r == 1'(b)) ? `CRS_OFS_AF
                    : `CRS_OFS_AF_ALT))
                begin
                    acc_r[b] <= pwdata[15:8];
                    flg_r[b] <= pwdata[7:0];
                end
                else if (alu_go && af_sel_r == 1'(b))
                begin
                    if (alu_wr) acc_r[b] <= alu_res;
                    flg_r[b] <= flg_nxt;
                end
            end
            for (genvar p = 0; p < 3; p++)
            begin : g_pair
                always_ff @(posedge clk_sys or negedge rst_n)
                begin
                    if (!rst_n)
                        gp_r[b][p] <= `CRS_RST_WORD;
                    else if (apb_wr && paddr == 8'(((bank_sel_r == 1'(b))
                        ? `CRS_OFS_PAIR1 : `CRS_OFS_ALT_PAIR1) + p * `CRS_WORD_STEP))
                        gp_r[b][p] <= pwdata[15:0];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign bus_out = bus_r;
    assign ir_out = ir_r;
    assign dec_out = dec_r;
    assign flags_out = flg_a;
    assign stk_addr = stk_addr_r;
    assign idx_addr = idx_addr_r;
    assign ptr_addr = ptr_addr_r;
    assign int_addr = int_addr_r;
    assign int_addr_vld = int_vld_r;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_fetch_addr_pc: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_r == CRS_ST_IDLE && fetch_req |=> bus_out.fetch && bus_out.addr == $past(pc_r))
        else $error("fetch address differs from program counter");
    a_pc_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_r == CRS_ST_IDLE && fetch_req && !jump_req && !apb_wr
        |=> pc_r == $past(pc_r) + `CRS_PC_STEP)
        else $error("program counter not incremented after fetch");
    a_jump_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
        jump_req && !apb_wr |=> pc_r == $past(jump_target))
        else $error("jump target not loaded");
    a_stack_lifo: assert property (@(posedge clk_sys) disable iff (!rst_n)
        push_req && !apb_wr ##1 pop_req && !push_req && !apb_wr
        |=> stk_addr == $past(stk_addr) && sp_r == $past(sp_r, 2))
        else $error("pop does not return to pushed slot");
    a_idx_signed: assert property (@(posedge clk_sys) disable iff (!rst_n)
        idx_req && !idx_sel && idx_disp[7] |=> idx_addr < $past(ix_r) || $past(ix_r) < 16'h0080)
        else $error("negative displacement not subtracted");
    a_int_page: assert property (@(posedge clk_sys) disable iff (!rst_n)
        int_ack && vec_mode_r |=> int_addr_vld && int_addr[15:8] == $past(ipage_r)
        && int_addr[7:0] == $past(int_vec_lo))
        else $error("vectored call address wrong");
    a_rfsh_seq: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_r == CRS_ST_IDLE && fetch_req && !apb_wr ##1 !apb_wr
        |=> bus_out.rfsh && rfsh_r == $past(rfsh_r) + `CRS_RFSH_STEP
        && bus_out.addr[6:0] == $past(rfsh_r))
        else $error("refresh cycle wrong after fetch");
    a_xchg_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
        xchg_af |=> af_sel_r != $past(af_sel_r) ##1 (xchg_af || $stable(af_sel_r)))
        else $error("accumulator exchange not single step");
    a_zero_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        alu_go && alu_req.op == CRS_XOR && alu_req.opnd == acc_a && !apb_wr
        |=> flags_out[`CRS_FLG_Z] || $past(xchg_af))
        else $error("zero result did not set zero flag");
    a_ptr_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ptr_req && ptr_hi && ptr_sel == 2'b11 |=> ptr_addr == $past(sp_r) + `CRS_PTR_STEP)
        else $error("high byte pointer not incremented");
endmodule

/* verif/crs_mem_model.sv */
// crs_mem_model: opcode memory and interrupting peripheral
// assumes bus_out of crs_core on the same clock
`timescale 1ns/1ns
module crs_mem_model
    import crs_pkg::*;
(
    // core side
    input wire logic clk_sys,
    input wire crs_bus_t bus_out,
    input wire logic int_ack,
    // answers
    output logic [7:0] fetch_data,
    output logic [7:0] int_vec_lo
);
    logic [7:0] last_r = 8'h00; // last opcode put on the bus
    // remember the opcode so the released bus can differ from it
    always_ff @(posedge clk_sys)
        if (bus_out.fetch)
            last_r <= bus_out.addr[7:0] ^ 8'h5a;
    // opcode is a fixed function of the address; released bus is inverted
    assign fetch_data = bus_out.fetch ? bus_out.addr[7:0] ^ 8'h5a : ~last_r;
    // vector low byte only while acknowledged
    assign int_vec_lo = int_ack ? 8'hc4 : 8'h3b;
endmodule

/* verif/tb.sv */
// tb: directed bench for crs_core
// assumes crs_mem_model answers fetches and interrupt acknowledges
`timescale 1ns/1ns
`include "crs_regs.svh"
module tb
    import crs_pkg::*;
;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr, fetch_data, idx_disp, int_vec_lo, ir_out, flags_out;
    logic [31:0] pwdata, prdata, q;
    logic fetch_req, jump_req, push_req, pop_req, xchg_af, xchg_bank, alu_go;
    logic idx_req, idx_sel, ptr_req, ptr_hi, int_ack, int_addr_vld;
    logic [15:0] jump_target, stk_addr, idx_addr, ptr_addr, int_addr;
    logic [1:0] ptr_sel;
    crs_alu_req_t alu_req;
    crs_bus_t bus_out;
    crs_dec_t dec_out;
    int miscompares, n_tests;
    crs_core dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .fetch_req, .fetch_data, .jump_req, .jump_target, .push_req,
        .pop_req, .xchg_af, .xchg_bank, .alu_go, .alu_req, .idx_req, .idx_sel, .idx_disp,
        .ptr_req, .ptr_sel, .ptr_hi, .int_ack, .int_vec_lo, .bus_out, .ir_out, .dec_out,
        .flags_out, .stk_addr, .idx_addr, .ptr_addr, .int_addr, .int_addr_vld);
    crs_mem_model mem (.clk_sys, .bus_out, .int_ack, .fetch_data, .int_vec_lo);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer; waits for pready, result left in q and e
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // no request driven; wait for the next edge, then settle past it
    task edge1;
        @(posedge clk_sys);
        #1;
    endtask
    task finish_test;
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        logic [7:0] ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, ofs[i], 32'hffff_a5c3);
            apb(1'b0, ofs[i], 32'h0);
            chk(q, i < 4 ? 32'h0000_a5c3 : 32'h0000_00c3);
        end
        chk({31'h0, pready}, 32'h1);
        apb(1'b1, 8'h44, 32'h1);
        chk({31'h0, e}, 32'h1); // unmapped write refused
        apb(1'b1, `CRS_OFS_IR, 32'hff);
        apb(1'b0, `CRS_OFS_IR, 32'h0);
        chk(q, 32'h0);
    endtask
    task t_fetch;
        apb(1'b1, `CRS_OFS_PC, 32'h0123);
        apb(1'b1, `CRS_OFS_RFSH, 32'h7f);
        @(posedge clk_sys); fetch_req <= 1'b1;
        @(posedge clk_sys); fetch_req <= 1'b0; #1;
        chk({bus_out.addr, bus_out.fetch}, {15'h0, 16'h0123, 1'b1});
        edge1();
        chk({bus_out.addr, bus_out.rfsh}, {15'h0, 16'h007f, 1'b1});
        chk({ir_out, dec_out}, {16'h0, 16'h7979});
        repeat (2) @(posedge clk_sys);
        apb(1'b0, `CRS_OFS_PC, 32'h0);
        chk(q, 32'h0124);
        apb(1'b0, `CRS_OFS_RFSH, 32'h0);
        chk(q, 32'h0);
        @(posedge clk_sys); fetch_req <= 1'b1; jump_req <= 1'b1; jump_target <= 16'hbeef;
        @(posedge clk_sys); fetch_req <= 1'b0; jump_req <= 1'b0;
        repeat (3) @(posedge clk_sys);
        apb(1'b0, `CRS_OFS_PC, 32'h0);
        chk(q, 32'hbeef);
    endtask
    task stk(input logic p, input logic [15:0] exp);
        @(posedge clk_sys); push_req <= p; pop_req <= !p;
        @(posedge clk_sys); push_req <= 1'b0; pop_req <= 1'b0; #1;
        chk(32'(stk_addr), 32'(exp));
    endtask
    task idx(input logic s, input logic [7:0] d, input logic [15:0] exp);
        @(posedge clk_sys); idx_req <= 1'b1; idx_sel <= s; idx_disp <= d;
        @(posedge clk_sys); idx_req <= 1'b0; #1;
        chk(32'(idx_addr), 32'(exp));
    endtask
    task ptr(input logic [1:0] s, input logic h, input logic [15:0] exp);
        @(posedge clk_sys); ptr_req <= 1'b1; ptr_sel <= s; ptr_hi <= h;
        @(posedge clk_sys); ptr_req <= 1'b0; #1;
        chk(32'(ptr_addr), 32'(exp));
    endtask
    // alu step on the active pair, then accumulator and flags read back
    task alu_chk(input crs_alu_op_t o, input logic [7:0] d, input logic [15:0] exp);
        @(posedge clk_sys); alu_go <= 1'b1; alu_req <= '{o, d, 3'h3};
        @(posedge clk_sys); alu_go <= 1'b0;
        apb(1'b0, `CRS_OFS_AF, 32'h0);
        chk(q, 32'(exp));
    endtask
    task t_addr;
        apb(1'b1, `CRS_OFS_SP, 32'h1000);
        stk(1'b1, 16'h0ffe); stk(1'b1, 16'h0ffc); stk(1'b0, 16'h0ffc); stk(1'b0, 16'h0ffe);
        @(posedge clk_sys); push_req <= 1'b1;
        @(posedge clk_sys); push_req <= 1'b0; pop_req <= 1'b1;
        @(posedge clk_sys); pop_req <= 1'b0; #1;
        chk(32'(stk_addr), 32'h0ffe);
        apb(1'b0, `CRS_OFS_SP, 32'h0);
        chk(q, 32'h1000);
        apb(1'b1, `CRS_OFS_IX, 32'h2000);
        apb(1'b1, `CRS_OFS_IY, 32'h0010);
        idx(1'b0, 8'h80, 16'h1f80); idx(1'b1, 8'h7f, 16'h008f); idx(1'b1, 8'hf0, 16'h0000);
        apb(1'b0, `CRS_OFS_IX, 32'h0);
        chk(q, 32'h2000);
        apb(1'b1, `CRS_OFS_CTRL, 32'h1);
        apb(1'b1, `CRS_OFS_IPAGE, 32'h12);
        @(posedge clk_sys); int_ack <= 1'b1;
        @(posedge clk_sys); int_ack <= 1'b0; #1;
        chk({int_addr, int_addr_vld}, {15'h0, 16'h12c4, 1'b1});
    endtask
    task t_xchg;
        apb(1'b1, `CRS_OFS_AF, 32'hab00);
        @(posedge clk_sys); xchg_af <= 1'b1;
        @(posedge clk_sys); xchg_af <= 1'b0;
        apb(1'b0, `CRS_OFS_AF_ALT, 32'h0);
        chk(q, 32'hab00);
        @(posedge clk_sys); alu_go <= 1'b1; alu_req <= '{CRS_XOR, 8'h00, 3'h0};
        @(posedge clk_sys); alu_go <= 1'b0; #1;
        chk(32'(flags_out[7:6]), 32'h1);
        @(posedge clk_sys); xchg_af <= 1'b1;
        @(posedge clk_sys); xchg_af <= 1'b0;
        apb(1'b0, `CRS_OFS_AF, 32'h0);
        chk(q, 32'hab00);
        alu_chk(CRS_ADD, 8'h60, 16'h0b01);
        alu_chk(CRS_CMP, 8'h0b, 16'h0b42);
        alu_chk(CRS_RR, 8'h00, 16'h8581);
        apb(1'b1, `CRS_OFS_PAIR1, 32'h3000);
        ptr(2'h0, 1'b1, 16'h3001);
        @(posedge clk_sys); xchg_bank <= 1'b1;
        @(posedge clk_sys); xchg_bank <= 1'b0;
        apb(1'b0, `CRS_OFS_ALT_PAIR1, 32'h0);
        chk(q, 32'h3000);
        apb(1'b1, `CRS_OFS_PAIR1 + 8'h08, 32'h4567);
        apb(1'b0, `CRS_OFS_PAIR1 + 8'h08, 32'h0);
        chk(q, 32'h4567);
        apb(1'b0, `CRS_OFS_ALT_PAIR1 + 8'h08, 32'h0);
        chk(q, 32'h0);
        ptr(2'h2, 1'b0, 16'h4567);
        ptr(2'h3, 1'b1, 16'h1001);
        apb(1'b0, `CRS_OFS_STAT, 32'h0);
        chk(q, 32'h6);
    endtask
    // ----------------------------------------
    // clock, reset, sequence, watchdog
    // ----------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial
    begin
        {rst_n, psel, penable, pwrite, fetch_req, jump_req, push_req, pop_req} = '0;
        {xchg_af, xchg_bank, alu_go, idx_req, idx_sel, ptr_req, ptr_hi, int_ack} = '0;
        {paddr, pwdata, jump_target, idx_disp, ptr_sel, alu_req} = '0;
        miscompares = 0; n_tests = 0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs(); t_fetch(); t_addr(); t_xchg();
        finish_test();
    end
    // a hang counts as a mismatch
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        finish_test();
    end
endmodule
